// File: rtl/line_frame_pkg.sv
// Shared constants and state types for the line sensor frame sequencer
package line_frame_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 40;
  localparam int US_NS          = 1000;
  localparam int US_CYCLES      = US_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sensor timing, in microseconds, and pixel count
  // ----------------------------------------------------------------
  localparam int READOUT_US     = 3710;
  localparam int PIXELS         = 3694;
  localparam int MIN_INT_US     = 10;
  localparam int DEFAULT_INT_US = 5000;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int INT_W          = 24;
  localparam int ADC_W          = 16;
  localparam int FRM_W          = 16;
  localparam int PIX_W          = 12;
  localparam int US_W           = 5;
  localparam int PT_W           = 8;
  localparam int FIFO_DEPTH     = 32;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {RD_IDLE, RD_SHIFT} rd_state_e;
  typedef enum logic [1:0] {
    CAP_IDLE, CAP_ARMED, CAP_RUN, CAP_DONE
  } cap_state_e;

endpackage : line_frame_pkg

// File: rtl/sample_fifo.sv
// Sample buffer FIFO with registered read data
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    cnt_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // Handshake terms
  // ----------------------------------------------------------------
  assign wr_ready_o = cnt_reg != FULL_CNT;
  assign push       = wr_valid_i && wr_ready_o;
  // Refill the output stage whenever it is empty or being taken
  assign pop        = (cnt_reg != '0) && (!out_valid_reg || rd_ready_i);
  assign rd_valid_o = out_valid_reg;
  assign rd_data_o  = out_data_reg;

  // Storage array, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Output register stage keeps read data off the array path
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (pop) begin
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem[rd_ptr_reg];
    end else if (rd_ready_i) begin
      out_valid_reg <= 1'b0;
    end
  end

endmodule : sample_fifo

// File: rtl/line_sensor_frame_timing.sv
// Frame timing and readout sequencer for a linear image sensor
// Operation
// - Frames run from reset or new settings, acquisition or not
// - Next frame starts the cycle the current one ends; equal lengths
// - Every frame integrates for the programmed integration period
// - Frame start transfers all charges to the shift register at once
// - Pixels then shift out one at a time to the ADC
// - Samples are stored only while an acquisition runs, else dropped
// - Host fetches stored samples during and after acquisition, as the 32-deep buffer fills; device delivers them
// - Shifting out a whole frame takes the fixed readout period
// - No frame is shorter than the readout period
// - Full readout after every frame, even without acquisition; a capture stall on a full FIFO can cut it short
// - Integration period sets frame length in normal operation
// - Periods down to 10 us accepted; shutter used below readout
// - Short periods: frame is least multiple reaching readout period
// - Shutter clears charge at each repeated period but the last
// - Integration period defaults to 5000 us after reset
`timescale 1ns/100ps
module line_sensor_frame_timing
  import line_frame_pkg::*;
#(
  parameter int READOUT_US_P = line_frame_pkg::READOUT_US,
  parameter int PIXELS_P     = line_frame_pkg::PIXELS
) (
  input  wire logic                              CLK_I,
  input  wire logic                              NRST_I,
  input  wire logic                              CFG_APPLY_I,
  input  wire logic [line_frame_pkg::INT_W-1:0]  CFG_INT_US_I,
  input  wire logic                              ACQ_START_I,
  input  wire logic [line_frame_pkg::FRM_W-1:0]  ACQ_FRAMES_I,
  output logic                                   ACQ_BUSY_O,
  output logic                                   ACQ_DONE_O,
  output logic                                   OVERRUN_O,
  output logic                                   XFER_O,
  output logic                                   SHUTTER_O,
  output logic                                   PIX_SHIFT_O,
  input  wire logic                              ADC_VALID_I,
  input  wire logic [line_frame_pkg::ADC_W-1:0]  ADC_DATA_I,
  output logic      [line_frame_pkg::ADC_W-1:0]  RD_DATA_O,
  output logic                                   RD_VALID_O,
  input  wire logic                              RD_READY_I
);

  import line_frame_pkg::*;

  // ----------------------------------------------------------------
  // Derived counts
  // ----------------------------------------------------------------
  // Pitch taken from one cycle less than the period, so unless a capture
  // stall holds it, the last shift lands before the next frame boundary can cut the readout
  localparam int PIX_CYCLES = (READOUT_US_P * US_CYCLES - 1) / PIXELS_P;
  localparam logic [US_W-1:0]  US_LAST   = US_W'(US_CYCLES - 1);
  localparam logic [PT_W-1:0]  PIX_LAST  = PT_W'(PIX_CYCLES - 1);
  localparam logic [PIX_W-1:0] PIX_FINAL = PIX_W'(PIXELS_P - 1);
  localparam logic [INT_W:0]   RO_US     = (INT_W+1)'(READOUT_US_P);
  localparam logic [INT_W-1:0] INT_MIN   = INT_W'(MIN_INT_US);
  localparam logic [INT_W-1:0] INT_DEF   = INT_W'(DEFAULT_INT_US);
  localparam logic [INT_W-1:0] INT_RO    = INT_W'(READOUT_US_P);

  // Raise a too-short setting to the shortest supported period
  function automatic logic [INT_W-1:0] clamp_int(
    input logic [INT_W-1:0] req
  );
    clamp_int = (req < INT_MIN) ? INT_MIN : req;
  endfunction : clamp_int

  logic [US_W-1:0]  us_cnt_reg;
  logic             us_tick;
  logic [INT_W-1:0] int_us_reg;
  logic             start_reg;
  logic [INT_W-1:0] sub_cnt_reg;
  logic [INT_W-1:0] frame_us_reg;
  logic [INT_W:0]   frame_sum;
  logic             sub_end;
  logic             frame_end;
  logic             frame_start;
  rd_state_e        rd_state_reg;
  logic [PIX_W-1:0] pix_cnt_reg;
  logic [PT_W-1:0]  pix_tmr_reg;
  logic             stall;
  logic             shift_fire;
  cap_state_e       cap_state_reg;
  logic [FRM_W-1:0] frames_left_reg;
  logic             cap_run;
  logic             fifo_wr_valid;
  logic             fifo_wr_ready;
  logic             xfer_reg;
  logic             shutter_reg;
  logic             pix_shift_reg;
  logic             overrun_reg;

  // ----------------------------------------------------------------
  // Microsecond time base
  // ----------------------------------------------------------------
  // Realigned on the restart pulse so the first frame is a full one
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || CFG_APPLY_I || start_reg) begin
      us_cnt_reg <= '0;
    end else if (us_tick) begin
      us_cnt_reg <= '0;
    end else begin
      us_cnt_reg <= us_cnt_reg + 1'b1;
    end
  end

  assign us_tick = us_cnt_reg == US_LAST;

  // ----------------------------------------------------------------
  // Integration period setting
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      int_us_reg <= INT_DEF;
    end else if (CFG_APPLY_I) begin
      int_us_reg <= clamp_int(CFG_INT_US_I);
    end
  end

  // Restart pulse held through reset into the first cycle after release, and one cycle after new settings
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      start_reg <= 1'b1;
    end else begin
      start_reg <= CFG_APPLY_I;
    end
  end

  // ----------------------------------------------------------------
  // Frame timer
  // ----------------------------------------------------------------
  // A frame is a chain of integration periods; it closes at the first
  // period end whose running total reaches the readout period.
  assign sub_end   = us_tick && (sub_cnt_reg == int_us_reg - 1'b1);
  assign frame_sum = {1'b0, frame_us_reg} + {1'b0, int_us_reg};
  assign frame_end = sub_end && (frame_sum >= RO_US);
  // Back-to-back frames: the boundary is one cycle for both frames
  assign frame_start = frame_end || start_reg;

  // Position inside the current integration period
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || CFG_APPLY_I || start_reg) begin
      sub_cnt_reg <= '0;
    end else if (sub_end) begin
      sub_cnt_reg <= '0;
    end else if (us_tick) begin
      sub_cnt_reg <= sub_cnt_reg + 1'b1;
    end
  end

  // Time already spent in the frame, in whole periods
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || CFG_APPLY_I || start_reg) begin
      frame_us_reg <= '0;
    end else if (frame_end) begin
      frame_us_reg <= '0;
    end else if (sub_end) begin
      frame_us_reg <= frame_sum[INT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Sensor strobes
  // ----------------------------------------------------------------
  // Registered so the sensor pins are glitch free
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      xfer_reg    <= 1'b0;
      shutter_reg <= 1'b0;
    end else begin
      xfer_reg    <= frame_start;
      shutter_reg <= sub_end && !frame_end;
    end
  end

  assign XFER_O    = xfer_reg;
  assign SHUTTER_O = shutter_reg;

  // ----------------------------------------------------------------
  // Pixel readout
  // ----------------------------------------------------------------
  // A full FIFO holds the shift clock during capture; that costs time
  // out of the readout budget, so an undrained host can cause overrun.
  assign stall      = cap_run && !fifo_wr_ready;
  assign shift_fire = (rd_state_reg == RD_SHIFT)
                   && (pix_tmr_reg == PIX_LAST) && !stall;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      rd_state_reg <= RD_IDLE;
      pix_cnt_reg  <= '0;
      pix_tmr_reg  <= '0;
    end else if (frame_start) begin
      rd_state_reg <= RD_SHIFT;
      pix_cnt_reg  <= '0;
      pix_tmr_reg  <= '0;
    end else begin
      case (rd_state_reg)
        RD_IDLE: begin
          pix_tmr_reg <= '0;
        end
        RD_SHIFT: begin
          if (pix_tmr_reg != PIX_LAST) begin
            pix_tmr_reg <= pix_tmr_reg + 1'b1;
          end else if (!stall) begin
            pix_tmr_reg <= '0;
            pix_cnt_reg <= pix_cnt_reg + 1'b1;
            if (pix_cnt_reg == PIX_FINAL) begin
              rd_state_reg <= RD_IDLE;
            end
          end
        end
        default: begin
          rd_state_reg <= RD_IDLE;
        end
      endcase
    end
  end

  // One pulse per pixel to the shift register and ADC
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      pix_shift_reg <= 1'b0;
    end else begin
      pix_shift_reg <= shift_fire && !frame_start;
    end
  end

  assign PIX_SHIFT_O = pix_shift_reg;

  // Readout cut short by a frame boundary; set wins over clear
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      overrun_reg <= 1'b0;
    end else if (frame_end && (rd_state_reg == RD_SHIFT)) begin
      overrun_reg <= 1'b1;
    end else if (ACQ_START_I) begin
      overrun_reg <= 1'b0;
    end
  end

  assign OVERRUN_O = overrun_reg;

  // ----------------------------------------------------------------
  // Acquisition control
  // ----------------------------------------------------------------
  // Arming waits for a boundary; each later boundary closes one frame
  always_ff @(posedge CLK_I) begin
    if (!NRST_I || CFG_APPLY_I) begin
      cap_state_reg   <= CAP_IDLE;
      frames_left_reg <= '0;
    end else begin
      case (cap_state_reg)
        CAP_IDLE, CAP_DONE: begin
          if (ACQ_START_I && (ACQ_FRAMES_I != '0)) begin
            cap_state_reg   <= CAP_ARMED;
            frames_left_reg <= ACQ_FRAMES_I;
          end
        end
        CAP_ARMED: begin
          if (frame_start) begin
            cap_state_reg <= CAP_RUN;
          end
        end
        CAP_RUN: begin
          if (frame_start) begin
            frames_left_reg <= frames_left_reg - 1'b1;
            if (frames_left_reg == 1) begin
              cap_state_reg <= CAP_DONE;
            end
          end
        end
        default: begin
          cap_state_reg <= CAP_IDLE;
        end
      endcase
    end
  end

  assign cap_run    = cap_state_reg == CAP_RUN;
  assign ACQ_BUSY_O = (cap_state_reg == CAP_ARMED) || cap_run;
  assign ACQ_DONE_O = cap_state_reg == CAP_DONE;

  // ----------------------------------------------------------------
  // Sample storage
  // ----------------------------------------------------------------
  // Samples outside a capture are simply never offered to the buffer
  assign fifo_wr_valid = ADC_VALID_I && cap_run;

  sample_fifo #(
    .WIDTH (ADC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_store (
    .clk_i      (CLK_I),
    .nrst_i     (NRST_I),
    .wr_valid_i (fifo_wr_valid),
    .wr_ready_o (fifo_wr_ready),
    .wr_data_i  (ADC_DATA_I),
    .rd_valid_o (RD_VALID_O),
    .rd_ready_i (RD_READY_I),
    .rd_data_o  (RD_DATA_O)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_period_end;
    sub_end && !frame_end;
  endsequence

  sequence s_quiet_after_shift;
    PIX_SHIFT_O ##1 !PIX_SHIFT_O [*8];
  endsequence

  a_frames_on_apply: assert property (
    CFG_APPLY_I |=> frame_start ##1 XFER_O)
    else $error("no frame restart after new settings");

  a_no_frame_gap: assert property (
    frame_end |=> (frame_us_reg == '0) && (sub_cnt_reg == '0)
                  && (rd_state_reg == RD_SHIFT))
    else $error("gap or stale count at frame boundary");

  a_xfer_starts_rd: assert property (
    XFER_O |-> (rd_state_reg == RD_SHIFT) && (pix_cnt_reg == '0))
    else $error("transfer without fresh readout");

  a_frame_min_len: assert property (
    frame_end |-> (frame_sum >= RO_US)
                  && ({1'b0, frame_us_reg} < RO_US))
    else $error("frame length not least multiple");

  a_shutter_short: assert property (
    s_period_end |=> SHUTTER_O && ($past(int_us_reg) < INT_RO))
    else $error("shutter clear missing or in long mode");

  a_drop_idle: assert property (
    (cap_state_reg != CAP_RUN) |-> !fifo_wr_valid)
    else $error("sample stored outside capture");

  a_readout_done: assert property (
    (frame_end && !ACQ_BUSY_O) |-> (rd_state_reg == RD_IDLE))
    else $error("readout unfinished at frame end");

  a_default_int: assert property (
    $past(!NRST_I) && !$past(CFG_APPLY_I) |-> int_us_reg == INT_DEF)
    else $error("integration default wrong after reset");

  a_int_floor: assert property (
    int_us_reg >= INT_MIN)
    else $error("integration period below minimum");

  a_cap_boundary: assert property (
    $rose(cap_run) |-> $past(frame_start))
    else $error("capture started off a frame boundary");

  a_pix_spacing: assert property (
    PIX_SHIFT_O && (PIX_CYCLES > 9) |-> s_quiet_after_shift)
    else $error("pixel shifts too close together");

endmodule : line_sensor_frame_timing

// File: test/sensor_adc_model.sv
// Behavioural line sensor and ADC answering each pixel shift with a sample
`timescale 1ns/100ps
module sensor_adc_model
  import line_frame_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             xfer_i,
  input  wire logic             pix_shift_i,
  input  wire logic [2:0]       lat_i,
  output logic                  adc_valid_o,
  output logic      [ADC_W-1:0] adc_data_o
);
  // ----------------------------------------------------------------
  // Conversion pipeline
  // ----------------------------------------------------------------
  logic [7:0]       frame_reg = 8'h00;
  logic [7:0]       pix_reg   = 8'h00;
  logic [ADC_W-1:0] tag_reg   = '0;
  logic [2:0]       wait_reg  = 3'h0;
  logic             pend_reg  = 1'b0;

  // Idle outputs at time zero
  initial begin
    adc_valid_o = 1'b0;
    adc_data_o  = '0;
  end

  // Sample word holds frame and pixel number so the bench can place it
  always @(negedge clk_i) begin
    adc_valid_o <= 1'b0;
    // Stale word inverted, never mistaken for a fresh sample
    if (adc_valid_o) adc_data_o <= ~adc_data_o;
    // One pixel per shift, converted lat_i + 1 cycles after the shift
    if (pix_shift_i) begin
      tag_reg  <= {frame_reg, pix_reg};
      pix_reg  <= pix_reg + 8'h01;
      wait_reg <= lat_i;
      pend_reg <= 1'b1;
    end else if (pend_reg) begin
      if (wait_reg == 3'h0) begin
        adc_valid_o <= 1'b1;
        adc_data_o  <= tag_reg;
        pend_reg    <= 1'b0;
      end else begin
        wait_reg <= wait_reg - 3'h1;
      end
    end
    // Whole pixel row moves into the register in one step
    if (xfer_i) begin
      frame_reg <= frame_reg + 8'h01;
      pix_reg   <= 8'h00;
    end
  end
endmodule : sensor_adc_model

// File: test/tb_top.sv
// Self-checking bench for the line sensor frame sequencer
`timescale 1ns/100ps
module tb_top
  import line_frame_pkg::*;
;
  // ----------------------------------------------------------------
  // Scaled sensor timing keeps frames near a thousand cycles
  // ----------------------------------------------------------------
  localparam int RD_US = 40;
  localparam int NPIX  = 4;
  localparam int PCYC  = (RD_US * US_CYCLES - 1) / NPIX;

  logic             clk, nrst, cfg_apply, acq_start, busy, done, ovr;
  logic             xfer, shut, pix, adc_valid, rd_valid, rd_rdy;
  logic [INT_W-1:0] cfg_int;
  logic [FRM_W-1:0] acq_frames;
  logic [ADC_W-1:0] adc_data, rd_data;
  logic [2:0]       lat;
  logic [31:0]      seed = 32'h2F66719A;
  logic [7:0]       xfer_cnt = 8'h00;
  logic [ADC_W-1:0] rdq[$];
  int               num_errors = 0;
  int               n_checks = 0;

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  line_sensor_frame_timing #(.READOUT_US_P(RD_US), .PIXELS_P(NPIX))
    line_sensor_frame_timing_inst (
    .CLK_I(clk), .NRST_I(nrst), .CFG_APPLY_I(cfg_apply),
    .CFG_INT_US_I(cfg_int), .ACQ_START_I(acq_start),
    .ACQ_FRAMES_I(acq_frames), .ACQ_BUSY_O(busy), .ACQ_DONE_O(done),
    .OVERRUN_O(ovr), .XFER_O(xfer), .SHUTTER_O(shut), .PIX_SHIFT_O(pix),
    .ADC_VALID_I(adc_valid), .ADC_DATA_I(adc_data), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .RD_READY_I(rd_rdy));

  sensor_adc_model sensor_adc_model_inst (
    .clk_i(clk), .xfer_i(xfer), .pix_shift_i(pix), .lat_i(lat),
    .adc_valid_o(adc_valid), .adc_data_o(adc_data));

  // Taken words and frame count, seen at the edge the design uses
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_rdy === 1'b1) rdq.push_back(rd_data);
    if (xfer === 1'b1) xfer_cnt <= xfer_cnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // Expectations and comparisons
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Short requests are raised to the minimum period
  function automatic int int_eff(input int t);
    return (t < MIN_INT_US) ? MIN_INT_US : t;
  endfunction : int_eff

  // Periods per frame: least count reaching the readout time
  function automatic int reps(input int t);
    return (RD_US + int_eff(t) - 1) / int_eff(t);
  endfunction : reps

  task automatic chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [ADC_W-1:0] got,
                          input logic [ADC_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk_word

  task automatic print_verdict();
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // One frame from a transfer pulse up to and including the next one
  task automatic measure_frame(output int len, sh, px, f, l);
    len = 0;
    sh  = 0;
    px  = 0;
    f   = 0;
    l   = 0;
    do begin
      @(negedge clk);
      len++;
      if (shut === 1'b1) sh++;
      if (pix === 1'b1) begin
        px++;
        if (f == 0) f = len;
        l = len;
      end
    end while (xfer !== 1'b1 && len < 5000);
  endtask : measure_frame

  // Apply a period mid-frame, then time two whole frames
  task automatic run_int(input int t);
    int n, len, sh, px, f, l;
    @(negedge clk);
    cfg_int   = t[INT_W-1:0];
    cfg_apply = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      cfg_apply = 1'b0;
      n++;
    end while (xfer !== 1'b1 && n < 50);
    chk_cnt(n, 2); // Restart on new settings
    repeat (2) begin
      measure_frame(len, sh, px, f, l);
      chk_cnt(len, reps(t) * int_eff(t) * US_CYCLES); // Length
      chk_bit(len >= RD_US * US_CYCLES, 1'b1); // Floor
      chk_cnt(sh, reps(t) - 1); // Clears
      chk_cnt(px, NPIX); // Full readout
      chk_cnt(f, PCYC); // First shift after transfer
      chk_cnt(l, NPIX * PCYC); // Readout span
    end
  endtask : run_int

  // Capture nfr frames; stall holds the reader off to fill the buffer
  task automatic run_acq(input int nfr, input bit stall);
    logic [7:0] f0;
    int         n, nexp;
    rdq.delete();
    lat    = 3'(rnd() % 5);
    rd_rdy = 1'b1;
    repeat (1200) @(negedge clk);
    chk_cnt(rdq.size(), 0); // Dropped while idle
    acq_frames = nfr[FRM_W-1:0];
    acq_start  = 1'b1;
    @(negedge clk);
    acq_start = 1'b0;
    rd_rdy    = ~stall;
    chk_bit(busy, 1'b1); // Armed
    n = 0;
    while (xfer !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    f0 = xfer_cnt + 8'h01;
    // Start while busy must be ignored
    @(negedge clk);
    acq_frames = 16'(nfr + 2);
    acq_start  = 1'b1;
    @(negedge clk);
    acq_start = 1'b0;
    if (stall) begin
      repeat (11000) @(negedge clk);
      chk_bit(ovr, 1'b1); // Readout cut by full buffer
    end
    n = 0;
    while (done !== 1'b1 && n < 16000) begin
      @(negedge clk);
      rd_rdy = 1'(rnd() & 32'h1);
      n++;
    end
    chk_bit(done, 1'b1); // Ends on a boundary
    chk_bit(busy, 1'b0); // Released
    rd_rdy = 1'b1;
    repeat (300) @(negedge clk);
    chk_bit(rd_valid, 1'b0); // Fully delivered
    nexp = stall ? 33 : nfr * NPIX;
    if (!stall) chk_cnt(rdq.size(), nexp); // Whole frames only
    for (int i = 0; i < nexp && i < rdq.size(); i++) begin
      chk_word(rdq[i], {8'(f0 + i / NPIX), 8'(i % NPIX)}); // Order
    end
  endtask : run_acq

  // Main sequence
  initial begin
    int n, px;
    int tl[6] = '{7, 10, 13, 40, 41, 23};
    nrst       = 1'b0;
    cfg_apply  = 1'b0;
    cfg_int    = '0;
    acq_start  = 1'b0;
    acq_frames = '0;
    rd_rdy     = 1'b0;
    lat        = 3'h1;
    repeat (5) @(negedge clk);
    chk_bit(xfer, 1'b0); // Quiet in reset
    nrst = 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (xfer !== 1'b1 && n < 50);
    chk_cnt(n, 1); // Frames run from reset
    n  = 0;
    px = 0;
    repeat (4000) begin
      @(negedge clk);
      if (xfer === 1'b1) n++;
      if (pix === 1'b1) px++;
    end
    chk_cnt(n, 0); // Long default period
    chk_cnt(px, NPIX); // One readout only
    foreach (tl[i]) run_int(tl[i]);
    repeat (3) run_int(10 + int'(rnd() % 51));
    // Shutter mode with slack left for the slowest conversion
    run_int(11);
    run_acq(1, 1'b0);
    run_acq(3, 1'b0);
    chk_bit(ovr, 1'b0); // No cut readout
    run_acq(12, 1'b1);
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
